// >>> src/dpc_params.svh
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH
`define DPC_CLK_MHZ 200
`define DPC_LOSS_US 500
`define DPC_FTW_W 48
`define DPC_DAC_W 14
`define DPC_MOD_W 16
`define DPC_PER_W 32
`define DPC_ERR_W 24
`define DPC_GAIN_W 4
`define DPC_AVG_LOG2 4
`define DPC_DIV_STEPS 7'd65
`define DPC_ADDR_W 5
`define DPC_OFS_CTRL 5'h00
`define DPC_OFS_RDIV 5'h04
`define DPC_OFS_SDIV 5'h08
`define DPC_OFS_GAIN 5'h0c
`define DPC_OFS_STAT 5'h10
`define DPC_OFS_FTWL 5'h14
`define DPC_OFS_FTWH 5'h18
`define DPC_CTRL_RST 8'h00
`define DPC_MOD_RST 16'h0001
`define DPC_GAIN_RST 4'h0
`endif

// >>> src/dpc_pkg.sv
`include "dpc_params.svh"
package dpc_pkg;
    typedef struct packed {
        logic hold_auto;
        logic s_fall;
        logic s_half;
        logic r_fall;
        logic r_half;
        logic ref_sel;
        logic est_en;
        logic enable;
    } dpc_ctrl_t;
    typedef struct packed {
        logic [`DPC_MOD_W-1:0] modulus;
        logic half;
        logic fall;
    } dpc_div_cfg_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EST = 4'h2,
        ST_LOCK = 4'h4,
        ST_HOLD = 4'h8
    } dpc_state_t;
    typedef enum logic [2:0] {
        EST_WAIT = 3'h1,
        EST_COUNT = 3'h2,
        EST_CALC = 3'h4
    } dpc_est_t;
endpackage

// >>> src/dpc_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpc_params.svh"
module dpc_divider import dpc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic sig,
    input var dpc_div_cfg_t cfg,
    output logic pulse
);
    logic sig_d_r;
    logic half_r;
    logic half_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic [`DPC_MOD_W-1:0] cnt_r;
    logic [`DPC_MOD_W-1:0] cnt_nxt;
    wire edge_w = cfg.fall ? (sig_d_r & ~sig) : (~sig_d_r & sig);
    wire [`DPC_MOD_W-1:0] last_w = (cfg.modulus == '0) ? '0 : cfg.modulus - 1'b1;
    wire wrap_w = edge_w && (cnt_r == last_w);
    assign cnt_nxt = clr ? '0 : wrap_w ? '0 : edge_w ? cnt_r + 1'b1 : cnt_r;
    assign half_nxt = clr ? 1'b0 : (wrap_w && cfg.half) ? ~half_r : half_r;
    assign pulse_nxt = !clr && wrap_w && (!cfg.half || half_r);
    assign pulse = pulse_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sig_d_r <= 1'b0;
            half_r <= 1'b0;
            pulse_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            sig_d_r <= sig;
            half_r <= half_nxt;
            pulse_r <= pulse_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_div_wrap;
        !clr && edge_w && cnt_r == last_w |=> cnt_r == '0 && pulse_r == ($past(!cfg.half) || $past(half_r));
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap with a pulse");
    property p_div_fall;
        !clr && cfg.fall && $fell(sig) && cnt_r != last_w |=> cnt_r == $past(cnt_r) + 1'b1;
    endproperty
    a_div_fall: assert property (p_div_fall) else $error("falling edge not counted");
    property p_div_clr;
        clr |=> cnt_r == '0 && !pulse_r && !half_r;
    endproperty
    a_div_clr: assert property (p_div_clr) else $error("divider not cleared");
    c_div_pulse: cover property (pulse_r && cfg.half);
endmodule // dpc_divider
`default_nettype wire

// >>> src/dpc_estimator.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpc_params.svh"
module dpc_estimator import dpc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [`DPC_PER_W-1:0] period,
    input wire logic [`DPC_MOD_W:0] mult,
    output logic busy,
    output logic done,
    output logic [`DPC_FTW_W-1:0] quo
);
    localparam int NW = `DPC_MOD_W + 1 + `DPC_FTW_W;
    logic busy_r;
    logic done_r;
    logic [6:0] cnt_r;
    logic [`DPC_PER_W-1:0] per_r;
    logic [`DPC_PER_W:0] rem_r;
    logic [NW-1:0] num_r;
    logic [NW-1:0] acc_r;
    logic [`DPC_FTW_W-1:0] quo_r;
    wire [`DPC_PER_W:0] rem_sh_w = {rem_r[`DPC_PER_W-1:0], num_r[NW-1]};
    wire ge_w = rem_sh_w >= {1'b0, per_r};
    wire [NW-1:0] acc_nxt_w = {acc_r[NW-2:0], ge_w};
    assign busy = busy_r;
    assign done = done_r;
    assign quo = quo_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= '0;
            per_r <= '0;
            rem_r <= '0;
            num_r <= '0;
            acc_r <= '0;
            quo_r <= '0;
        end else begin
            done_r <= 1'b0;
            if (!busy_r && start) begin
                busy_r <= 1'b1;
                cnt_r <= `DPC_DIV_STEPS;
                per_r <= period;
                rem_r <= '0;
                num_r <= {mult, {`DPC_FTW_W{1'b0}}};
                acc_r <= '0;
            end else if (busy_r) begin
                rem_r <= ge_w ? rem_sh_w - {1'b0, per_r} : rem_sh_w;
                num_r <= {num_r[NW-2:0], 1'b0};
                acc_r <= acc_nxt_w;
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == 7'd1) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    quo_r <= (|acc_nxt_w[NW-1:`DPC_FTW_W]) ? '1 : acc_nxt_w[`DPC_FTW_W-1:0];
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_est_len;
        start && !busy_r |-> ##66 done_r;
    endproperty
    a_est_len: assert property (p_est_len) else $error("estimate not ready after 66 cycles");
endmodule // dpc_estimator
`default_nettype wire

// >>> src/dpc_core.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_params.svh"
module dpc_core import dpc_pkg::*; #(
    parameter int unsigned LOSS_CYC = `DPC_LOSS_US * `DPC_CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [`DPC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ref_a_in,
    input wire logic ref_b_in,
    input wire logic fed_back_clock_input,
    input wire logic hold_in,
    output logic hold_out,
    output logic hold_oe,
    output logic [`DPC_FTW_W-1:0] ftw_out,
    output logic dds_clk_out,
    output logic [`DPC_DAC_W-1:0] dac_word
);
    localparam int EW = `DPC_ERR_W;

    function automatic logic [31:0] dpc_be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                                 input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [`DPC_MOD_W:0] dpc_eff_mod(input logic [`DPC_MOD_W-1:0] m, input logic half);
        logic [`DPC_MOD_W:0] b;
        b = (m == '0) ? {{`DPC_MOD_W{1'b0}}, 1'b1} : {1'b0, m};
        return half ? {b[`DPC_MOD_W-1:0], 1'b0} : b;
    endfunction

    dpc_ctrl_t ctrl_r;
    logic [`DPC_MOD_W-1:0] rdiv_r;
    logic [`DPC_MOD_W-1:0] sdiv_r;
    logic [`DPC_GAIN_W-1:0] gain_r;
    logic ack_r;
    logic [31:0] rdata_r;
    dpc_state_t st_r;
    dpc_state_t st_nxt;
    dpc_est_t est_r;
    logic est_start_r;
    logic [`DPC_PER_W-1:0] est_per_r;
    logic ref_seen_r;
    logic fb_seen_r;
    logic [EW-2:0] tcnt_r;
    logic signed [EW-1:0] err_r;
    logic err_vld_r;
    logic [31:0] loss_cnt_r;
    logic [`DPC_FTW_W-1:0] ftw_r;
    logic [`DPC_FTW_W-1:0] ftw_nxt;
    logic [`DPC_FTW_W-1:0] phase_r;
    logic [`DPC_FTW_W+`DPC_AVG_LOG2-1:0] avg_sum_r;
    logic [`DPC_AVG_LOG2-1:0] avg_cnt_r;
    logic [`DPC_FTW_W-1:0] avg_r;
    logic avg_vld_r;
    logic pfd_ref_w;
    logic pfd_fb_w;
    logic est_busy_w;
    logic est_done_w;
    logic [`DPC_FTW_W-1:0] est_q_w;

    wire req_w = avs_read | avs_write;
    wire acc_w = req_w & ~ack_r;
    wire wr_w = avs_write & ack_r;
    wire sel_ctrl_w = avs_address == `DPC_OFS_CTRL;
    wire sel_rdiv_w = avs_address == `DPC_OFS_RDIV;
    wire sel_sdiv_w = avs_address == `DPC_OFS_SDIV;
    wire sel_gain_w = avs_address == `DPC_OFS_GAIN;
    wire sel_stat_w = avs_address == `DPC_OFS_STAT;
    wire sel_ftwl_w = avs_address == `DPC_OFS_FTWL;
    wire sel_ftwh_w = avs_address == `DPC_OFS_FTWH;
    wire [31:0] wr_ctrl_w = dpc_be_merge({24'h0, ctrl_r}, avs_writedata, avs_byteenable);
    wire [31:0] wr_rdiv_w = dpc_be_merge({16'h0, rdiv_r}, avs_writedata, avs_byteenable);
    wire [31:0] wr_sdiv_w = dpc_be_merge({16'h0, sdiv_r}, avs_writedata, avs_byteenable);
    wire [31:0] wr_gain_w = dpc_be_merge({28'h0, gain_r}, avs_writedata, avs_byteenable);
    wire lost_w = loss_cnt_r >= LOSS_CYC;
    wire hold_req_w = ctrl_r.hold_auto ? lost_w : hold_in;
    wire [31:0] stat_w = {24'h0, avg_vld_r, est_busy_w, lost_w, 1'b0, st_r};
    wire [31:0] rd_mux_w = sel_ctrl_w ? {24'h0, ctrl_r} :
                           sel_rdiv_w ? {16'h0, rdiv_r} :
                           sel_sdiv_w ? {16'h0, sdiv_r} :
                           sel_gain_w ? {28'h0, gain_r} :
                           sel_stat_w ? stat_w :
                           sel_ftwl_w ? ftw_r[31:0] :
                           sel_ftwh_w ? {16'h0, ftw_r[`DPC_FTW_W-1:32]} : 32'h0;
    wire ref_w = ctrl_r.ref_sel ? ref_b_in : ref_a_in;
    wire signed [`DPC_FTW_W-1:0] step_w = $signed({{(`DPC_FTW_W-EW){err_r[EW-1]}}, err_r}) <<< gain_r;
    wire loop_upd_w = (st_r == ST_LOCK) && err_vld_r && ctrl_r.enable && !hold_req_w;
    wire [`DPC_FTW_W+`DPC_AVG_LOG2-1:0] avg_tot_w = avg_sum_r + ftw_r;

    assign avs_waitrequest = req_w & ~ack_r;
    assign avs_readdata = rdata_r;
    assign hold_oe = ctrl_r.hold_auto;
    assign hold_out = st_r == ST_HOLD;
    assign ftw_out = ftw_r;
    assign dds_clk_out = phase_r[`DPC_FTW_W-1];
    assign dac_word = phase_r[`DPC_FTW_W-1 -: `DPC_DAC_W];

    dpc_divider u_rdiv (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(!ctrl_r.enable),
        .sig(ref_w),
        .cfg({rdiv_r, ctrl_r.r_half, ctrl_r.r_fall}),
        .pulse(pfd_ref_w)
    );

    dpc_divider u_sdiv (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(!ctrl_r.enable),
        .sig(fed_back_clock_input),
        .cfg({sdiv_r, ctrl_r.s_half, ctrl_r.s_fall}),
        .pulse(pfd_fb_w)
    );

    dpc_estimator u_est (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(est_start_r),
        .period(est_per_r),
        .mult(dpc_eff_mod(sdiv_r, ctrl_r.s_half)),
        .busy(est_busy_w),
        .done(est_done_w),
        .quo(est_q_w)
    );

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: if (ctrl_r.enable) st_nxt = ctrl_r.est_en ? ST_EST : ST_LOCK;
            ST_EST: begin
                if (!ctrl_r.enable) st_nxt = ST_IDLE;
                else if (hold_req_w) st_nxt = ST_HOLD;
                else if (est_done_w && est_r == EST_CALC) st_nxt = ST_LOCK;
            end
            ST_LOCK: begin
                if (!ctrl_r.enable) st_nxt = ST_IDLE;
                else if (hold_req_w) st_nxt = ST_HOLD;
            end
            ST_HOLD: begin
                if (!ctrl_r.enable) st_nxt = ST_IDLE;
                else if (!hold_req_w) st_nxt = ctrl_r.est_en ? ST_EST : ST_LOCK;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_comb begin
        ftw_nxt = ftw_r;
        if (st_nxt == ST_IDLE) ftw_nxt = '0;
        else if (st_nxt == ST_HOLD && st_r != ST_HOLD && avg_vld_r) ftw_nxt = avg_r;
        else if (st_r == ST_EST && st_nxt == ST_LOCK) ftw_nxt = est_q_w;
        else if (loop_upd_w) ftw_nxt = ftw_r + $unsigned(step_w);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            ctrl_r <= `DPC_CTRL_RST;
            rdiv_r <= `DPC_MOD_RST;
            sdiv_r <= `DPC_MOD_RST;
            gain_r <= `DPC_GAIN_RST;
        end else begin
            ack_r <= acc_w;
            if (avs_read && acc_w) rdata_r <= rd_mux_w;
            if (wr_w && sel_ctrl_w) ctrl_r <= dpc_ctrl_t'(wr_ctrl_w[7:0]);
            if (wr_w && sel_rdiv_w) rdiv_r <= wr_rdiv_w[`DPC_MOD_W-1:0];
            if (wr_w && sel_sdiv_w) sdiv_r <= wr_sdiv_w[`DPC_MOD_W-1:0];
            if (wr_w && sel_gain_w) gain_r <= wr_gain_w[`DPC_GAIN_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_seen_r <= 1'b0;
            fb_seen_r <= 1'b0;
            tcnt_r <= '0;
            err_r <= '0;
            err_vld_r <= 1'b0;
        end else begin
            err_vld_r <= 1'b0;
            if (ref_seen_r || fb_seen_r) tcnt_r <= (&tcnt_r) ? tcnt_r : tcnt_r + 1'b1;
            if (pfd_ref_w && pfd_fb_w) begin
                err_r <= '0;
                err_vld_r <= 1'b1;
                ref_seen_r <= 1'b0;
                fb_seen_r <= 1'b0;
            end else if (pfd_ref_w) begin
                if (fb_seen_r) begin
                    err_r <= -$signed({1'b0, tcnt_r});
                    err_vld_r <= 1'b1;
                    fb_seen_r <= 1'b0;
                end else begin
                    ref_seen_r <= 1'b1;
                    tcnt_r <= '0;
                end
            end else if (pfd_fb_w) begin
                if (ref_seen_r) begin
                    err_r <= $signed({1'b0, tcnt_r});
                    err_vld_r <= 1'b1;
                    ref_seen_r <= 1'b0;
                end else begin
                    fb_seen_r <= 1'b1;
                    tcnt_r <= '0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
            est_r <= EST_WAIT;
            est_start_r <= 1'b0;
            est_per_r <= '0;
            loss_cnt_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            est_start_r <= 1'b0;
            loss_cnt_r <= pfd_ref_w ? 32'h0 : lost_w ? loss_cnt_r : loss_cnt_r + 32'h1;
            if (st_r != ST_EST) begin
                est_r <= EST_WAIT;
            end else begin
                case (est_r)
                    EST_WAIT: if (pfd_ref_w) begin
                        est_r <= EST_COUNT;
                        est_per_r <= {{(`DPC_PER_W-1){1'b0}}, 1'b1};
                    end
                    EST_COUNT: begin
                        est_per_r <= pfd_ref_w ? est_per_r : est_per_r + 1'b1;
                        if (pfd_ref_w) begin
                            est_r <= EST_CALC;
                            est_start_r <= 1'b1;
                        end
                    end
                    EST_CALC: est_r <= EST_CALC;
                    default: est_r <= EST_WAIT;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ftw_r <= '0;
            phase_r <= '0;
            avg_sum_r <= '0;
            avg_cnt_r <= '0;
            avg_r <= '0;
            avg_vld_r <= 1'b0;
        end else begin
            ftw_r <= ftw_nxt;
            phase_r <= phase_r + ftw_r;
            if (st_r == ST_IDLE) begin
                avg_sum_r <= '0;
                avg_cnt_r <= '0;
                avg_vld_r <= 1'b0;
            end else if (loop_upd_w) begin
                avg_cnt_r <= avg_cnt_r + 1'b1;
                avg_sum_r <= (&avg_cnt_r) ? '0 : avg_tot_w;
                if (&avg_cnt_r) begin
                    avg_r <= avg_tot_w[`DPC_FTW_W+`DPC_AVG_LOG2-1:`DPC_AVG_LOG2];
                    avg_vld_r <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_est_quiet;
        st_r == ST_EST && $past(st_r) == ST_EST |-> $stable(ftw_r);
    endproperty
    a_est_quiet: assert property (p_est_quiet) else $error("tuning moved during estimation");
    property p_est_load;
        st_r == ST_EST && st_nxt == ST_LOCK |=> ftw_r == $past(est_q_w);
    endproperty
    a_est_load: assert property (p_est_load) else $error("estimate not loaded");
    property p_est_lock;
        st_r == ST_LOCK && $past(st_r) == ST_EST |-> $past(est_done_w) && $past(est_r) == EST_CALC;
    endproperty
    a_est_lock: assert property (p_est_lock) else $error("loop started before estimate");
    property p_lock_step;
        loop_upd_w |=> ftw_r == $past(ftw_r) + $unsigned($past(step_w));
    endproperty
    a_lock_step: assert property (p_lock_step) else $error("loop word not applied");
    property p_hold_entry;
        st_r != ST_HOLD && st_nxt == ST_HOLD && avg_vld_r |=> ftw_r == $past(avg_r);
    endproperty
    a_hold_entry: assert property (p_hold_entry) else $error("holdover not at average");
    property p_hold_freeze;
        st_r == ST_HOLD && st_nxt == ST_HOLD |=> $stable(ftw_r);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("holdover word drifted");
    property p_hold_runs;
        st_r == ST_HOLD |=> phase_r == $past(phase_r) + $past(ftw_r);
    endproperty
    a_hold_runs: assert property (p_hold_runs) else $error("synthesizer stopped in holdover");
    property p_hold_pin;
        !ctrl_r.hold_auto && hold_in && ctrl_r.enable && st_r == ST_LOCK |=> st_r == ST_HOLD && !hold_oe;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("manual holdover ignored");
    c_est_lock: cover property (st_r == ST_EST ##1 st_r == ST_LOCK);
    c_lock_hold: cover property (st_r == ST_LOCK ##1 st_r == ST_HOLD);
    c_hold_back: cover property (st_r == ST_HOLD ##1 st_r == ST_LOCK);
endmodule // dpc_core
`default_nettype wire

// >>> testbench/dpc_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_ref_src (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic refs_on,
    input wire logic dds_clk_out,
    output logic ref_a_in,
    output logic ref_b_in,
    output logic fed_back_clock_input
);
    logic [3:0] cnt_r;
    logic [1:0] dly_r;
    // References run from the system clock so divided periods are whole cycles.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 4'h0;
            dly_r <= 2'h0;
        end else begin
            cnt_r <= refs_on ? cnt_r + 4'h1 : cnt_r;
            dly_r <= {dly_r[0], dds_clk_out};
        end
    end
    assign ref_a_in = refs_on & cnt_r[2];
    assign ref_b_in = refs_on & cnt_r[3];
    // The reconstruction filter returns the synthesized clock two cycles late.
    assign fed_back_clock_input = dly_r[1];
endmodule // dpc_ref_src
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import dpc_pkg::*;;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ref_a_in;
    logic ref_b_in;
    logic fb_in;
    logic hold_in = 1'b0;
    logic hold_out;
    logic hold_oe;
    logic dds_clk_out;
    logic [47:0] ftw_out;
    logic [13:0] dac_word;
    logic refs_on = 1'b1;
    logic [31:0] rd;
    logic [47:0] f;
    logic dprev;
    int tog;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] ctl [4] = '{8'h03, 8'h1b, 8'h07, 8'h63};
    logic [47:0] fexp [4] = '{48'h1000_0000_0000, 48'h0800_0000_0000, 48'h0800_0000_0000, 48'h2000_0000_0000};

    always #2.5 core_clk = ~core_clk;

    dpc_core #(.LOSS_CYC(200)) u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_a_in(ref_a_in),
        .ref_b_in(ref_b_in), .fed_back_clock_input(fb_in), .hold_in(hold_in), .hold_out(hold_out),
        .hold_oe(hold_oe), .ftw_out(ftw_out), .dds_clk_out(dds_clk_out), .dac_word(dac_word)
    );

    dpc_ref_src u_src (
        .core_clk(core_clk), .arst_n(arst_n), .refs_on(refs_on), .dds_clk_out(dds_clk_out),
        .ref_a_in(ref_a_in), .ref_b_in(ref_b_in), .fed_back_clock_input(fb_in)
    );

    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 50) begin
                check("bus_wait", 48'h1, 48'h0);
                finish_test();
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(name, {16'h0, rd & m}, {16'h0, e});
    endtask

    // Mode 0 waits for the tuning word to differ from v, 1 for a rise above v, 2 for the holdover flag to equal v.
    task automatic wait_for(input int k, input logic [47:0] v);
        int n;
        n = 0;
        while (!((k == 0 && ftw_out !== v) || (k == 1 && ftw_out > v) || (k == 2 && hold_out === v[0]))) begin
            @(posedge core_clk);
            n++;
            if (n > 5000) begin
                check("wait_bound", 48'h1, 48'h0);
                finish_test();
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        rdchk("ctrl", 5'h00, 32'hffff_ffff, 32'h0);
        rdchk("r_mod", 5'h04, 32'hffff_ffff, 32'h1);
        rdchk("s_mod", 5'h08, 32'hffff_ffff, 32'h1);
        rdchk("status", 5'h10, 32'hf, 32'h1);
        rdchk("ftw_lo", 5'h14, 32'hffff_ffff, 32'h0);
        rdchk("ftw_hi", 5'h18, 32'hffff_ffff, 32'h0);
        rdchk("gain", 5'h0c, 32'hffff_ffff, 32'h0);
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rdchk("unmapped", 5'h1c, 32'hffff_ffff, 32'h0);
        bus(1'b1, 5'h04, 32'h4);
        bus(1'b1, 5'h08, 32'h2);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 5'h00, 32'h0);
            bus(1'b1, 5'h00, {24'h0, ctl[i]});
            rdchk("est_state", 5'h10, 32'hf, 32'h2);
            check("est_ftw", ftw_out, 48'h0);
            wait_for(0, 48'h0);
            check("est_load", ftw_out, fexp[i]);
            rdchk("lock_state", 5'h10, 32'hf, 32'h4);
        end
        bus(1'b1, 5'h08, 32'h3);
        bus(1'b1, 5'h0c, 32'h2);
        rdchk("gain_set", 5'h0c, 32'hffff_ffff, 32'h2);
        wait_for(1, fexp[3]);
        check("servo_dir", {47'h0, ftw_out > fexp[3]}, 48'h1);
        for (int k = 0; k < 1000 && !rd[7]; k++) begin
            bus(1'b0, 5'h10, 32'h0);
        end
        check("avg_valid", {47'h0, rd[7]}, 48'h1);
        hold_in <= 1'b1;
        wait_for(2, 48'h1);
        rdchk("hold_state", 5'h10, 32'hf, 32'h8);
        check("hold_oe_man", {47'h0, hold_oe}, 48'h0);
        f = ftw_out;
        tog = 0;
        dprev = dds_clk_out;
        repeat (200) begin
            @(posedge core_clk);
            if (dds_clk_out !== dprev) tog++;
            dprev = dds_clk_out;
        end
        check("hold_ftw", ftw_out, f);
        check("hold_clk", {47'h0, tog > 40}, 48'h1);
        check("dac_msb", {47'h0, dac_word[13]}, {47'h0, dds_clk_out});
        hold_in <= 1'b0;
        wait_for(2, 48'h0);
        bus(1'b1, 5'h00, 32'h81);
        refs_on <= 1'b0;
        wait_for(2, 48'h1);
        check("hold_oe_auto", {47'h0, hold_oe}, 48'h1);
        refs_on <= 1'b1;
        wait_for(2, 48'h0);
        check("hold_left", {47'h0, hold_out}, 48'h0);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
